// >>> hw/ptbd_pkg.sv
/*
  Package for the PCI target backend data path: command codes, window
  sizes, read queue depth and the packed types shared by the ports.
  Assumes a 64-bit capable PCI bus sampled on one clock.
*/
`default_nettype none

package ptbd_pkg;

  // ==========================================================
  // Bus commands and widths
  localparam logic [3:0]  CMD_MEM_READ  = 4'h6;
  localparam logic [3:0]  CMD_MEM_WRITE = 4'h7;
  localparam int          AD_W          = 64;
  localparam int          WADDR_W       = 30;
  localparam logic [31:0] BAR_MASK      = 32'hFFFF_F000;
  localparam int          ADDR_LO       = 2;
  localparam int          ADDR_HI       = 31;

  // ==========================================================
  // Read queue and address to data lag
  localparam int          RQ_DEPTH  = 4;
  localparam logic [3:0]  RQ_DEPTH4 = 4'h4;
  localparam int          LAG_W     = 3;
  localparam int          LAG_DEPTH = 8;

  // ==========================================================
  // Pointer steps and lane constants
  localparam logic [WADDR_W-1:0] STEP_NARROW = 30'h0000_0001;
  localparam logic [WADDR_W-1:0] STEP_WIDE   = 30'h0000_0002;
  localparam logic [1:0]         FETCH_NARROW = 2'h1;
  localparam logic [1:0]         FETCH_WIDE   = 2'h3;
  localparam logic [3:0]         LANES_OFF    = 4'h0;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    PH_IDLE  = 2'b00,
    PH_CLAIM = 2'b01,
    PH_DATA  = 2'b10
  } ptbd_phase_t;

  typedef struct packed {
    logic            frame_n;
    logic            irdy_n;
    logic            req64_n;
    logic [7:0]      cbe_n;
    logic [AD_W-1:0] ad;
  } ptbd_pci_in_t;

  typedef struct packed {
    logic       hit_strobe;
    logic       wide_strobe;
    logic [1:0] space_select_flags;
    logic       dir_read_flag;
    logic       dir_write_flag;
  } ptbd_cyc_t;

endpackage

`default_nettype wire

// >>> hw/ptbd_top.sv
/*
  PCI target data path between the PCI bus and a user backend: memory
  read/write decode, hit strobes, zero-wait and paced bursts, pointer
  stepping and address to data lag.
  Assumes all inputs synchronous to clk and a master that keeps the
  PCI protocol; the tri-state AD pins are split into value and enable.
*/
`timescale 1ns/100ps
`default_nettype none

// Operation
// R1: Command 0111 with frame means memory write
// R2: Command 0110 with frame means memory read
// R3: Address hit: strobe cycle 3, DEVSELn cycle 4
// R4: REQ64n hit: wide strobe, ACK64n with DEVSELn
// R5: Zero-wait backend transfers run every cycle
// R6: Pointer advances after each active fetch strobe
// R7: Wide transfers step the pointer by two
// R8: Burst write: TRDYn off, backend one later
// R9: Backend prefetches three words on burst reads
// R10: Burst read ends with TRDYn off
// R11: Write accept rises two cycles before ready; here TRDYn goes low one cycle after accept
// R12: TRDYn after accept, then qualified write data
// R13: Qualifier timing depends on master IRDYn
// R14: Read avail rises one cycle before data
// R15: Read avail gives fetch strobe, then TRDYn
// R16: IRDYn pause drops qualifiers one cycle later
// R17: Backend not ready holds TRDYn off
// R18: Backend takes two words after accept drops; here it takes one, as TRDYn follows accept by one cycle
// R19: Backend supplies one word after avail drops
// R20: Avail drop stops fetch, then TRDYn off
// R21: Lag zero: data valid with qualifier
// R22: Lag N: data valid N cycles later
// R23: Space and direction flags held between hits
// R24: Wide strobe with hit means 64-bit path
// R25: Master end drops TRDYn and qualifiers
module ptbd_top
  import ptbd_pkg::*;
(
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          reset,
  // PCI inputs and target controls
  input  wire ptbd_pkg::ptbd_pci_in_t        pci_in,
  output var  logic                          devsel_n,
  output var  logic                          ack64_n,
  output var  logic                          trdy_n,
  output var  logic [ptbd_pkg::AD_W-1:0]     ad_out,
  output var  logic                          ad_oe,
  // Window bases and lag selector
  input  wire logic [31:0]                   bar0_base,
  input  wire logic [31:0]                   bar1_base,
  input  wire logic [ptbd_pkg::LAG_W-1:0]    addr_data_lag_sel,
  // Backend handshake
  input  wire logic                          backend_write_accept,
  input  wire logic                          backend_read_avail,
  input  wire logic [ptbd_pkg::AD_W-1:0]     mem_rdata,
  output var  ptbd_pkg::ptbd_cyc_t           cyc,
  output var  logic [ptbd_pkg::WADDR_W-1:0]  mem_addr,
  output var  logic [ptbd_pkg::AD_W-1:0]     mem_wdata,
  output var  logic [7:0]                    write_lane_qualifier,
  output var  logic [1:0]                    read_fetch_strobe
);
  import ptbd_pkg::*;

  // ==========================================================
  // Address window decode, used for both windows
  function automatic logic bar_hit(input logic [31:0] addr, input logic [31:0] base);
    bar_hit = ((addr & BAR_MASK) == (base & BAR_MASK));
  endfunction

  // ==========================================================
  // State
  typedef struct packed {
    ptbd_phase_t                      phase;
    logic                             frame_q;
    logic                             wide;
    logic                             is_read;
    ptbd_cyc_t                        cyc;
    logic                             devsel_n;
    logic                             ack64_n;
    logic                             trdy_n;
    logic                             ad_oe;
    logic [AD_W-1:0]                  ad_out;
    logic [WADDR_W-1:0]               mem_addr;
    logic [AD_W-1:0]                  wdata;
    logic [7:0]                       wlq;
    logic [1:0]                       fetch;
    logic [LAG_DEPTH-1:0]             lag_pipe;
    logic [3:0]                       pend;
    logic [3:0]                       occ;
    logic [RQ_DEPTH-1:0][AD_W-1:0]    rq;
  } ptbd_state_t;

  ptbd_state_t s_r;
  ptbd_state_t s_nxt;

  logic [3:0]  cmd;
  logic        hit0;
  logic        hit1;
  logic        start;
  logic        xfer;
  logic        fin;
  logic        quit;
  logic        cap;
  logic        pop;
  logic        issue;
  logic [3:0]  used;
  logic [WADDR_W-1:0] step;

  // Decode of the current bus cycle
  assign cmd   = pci_in.cbe_n[3:0];
  assign hit0  = bar_hit(pci_in.ad[31:0], bar0_base);
  assign hit1  = bar_hit(pci_in.ad[31:0], bar1_base);
  assign start = !pci_in.frame_n && s_r.frame_q && (hit0 || hit1) &&
                 ((cmd == CMD_MEM_WRITE) || (cmd == CMD_MEM_READ));
  assign xfer  = !pci_in.irdy_n && !s_r.trdy_n;
  assign fin   = xfer && pci_in.frame_n;
  assign quit  = pci_in.frame_n && pci_in.irdy_n;
  assign step  = s_r.wide ? STEP_WIDE : STEP_NARROW;
  // Lagged capture of backend read data
  assign cap   = (addr_data_lag_sel == '0) ? (s_r.fetch != '0) :
                 s_r.lag_pipe[addr_data_lag_sel - LAG_W'(1)];
  assign used  = s_r.occ + s_r.pend + {3'h0, !s_r.trdy_n};

  // Next-state logic for decode, claim and data phases
  always_comb begin
    s_nxt          = s_r;
    s_nxt.frame_q  = pci_in.frame_n;
    s_nxt.cyc.hit_strobe  = 1'b0;
    s_nxt.cyc.wide_strobe = 1'b0;
    s_nxt.wlq      = '0;
    s_nxt.fetch    = '0;
    s_nxt.lag_pipe = {s_r.lag_pipe[LAG_DEPTH-2:0], (s_r.fetch != '0)};
    issue          = 1'b0;
    pop            = 1'b0;
    // Write pointer moves once each posted word has been shown
    if (s_r.wlq != '0) begin
      s_nxt.mem_addr = s_r.mem_addr + step; // see R7
    end
    // Read pointer moves on the cycle after an active fetch
    if (s_r.fetch != '0) begin
      s_nxt.mem_addr = s_r.mem_addr + step; // see R6, R7
    end
    case (s_r.phase)
      PH_IDLE: begin
        if (start) begin
          s_nxt.phase           = PH_CLAIM;
          s_nxt.cyc.hit_strobe  = 1'b1; // see R3
          s_nxt.cyc.wide_strobe = !pci_in.req64_n; // see R4, R24
          s_nxt.wide            = !pci_in.req64_n;
          s_nxt.is_read         = (cmd == CMD_MEM_READ); // see R2
          s_nxt.cyc.dir_read_flag  = (cmd == CMD_MEM_READ);
          s_nxt.cyc.dir_write_flag = (cmd == CMD_MEM_WRITE); // see R1
          s_nxt.cyc.space_select_flags = {hit1, hit0}; // see R23
          s_nxt.mem_addr        = pci_in.ad[ADDR_HI:ADDR_LO];
          s_nxt.pend            = '0;
          s_nxt.occ             = '0;
          s_nxt.lag_pipe        = '0;
        end
      end
      PH_CLAIM: begin
        s_nxt.phase    = PH_DATA;
        s_nxt.devsel_n = 1'b0; // see R3
        s_nxt.ack64_n  = !s_r.wide; // see R4
        s_nxt.ad_oe    = s_r.is_read;
      end
      default: begin
        if (!s_r.is_read) begin
          // Write: ready follows accept one cycle later
          s_nxt.trdy_n = !backend_write_accept; // see R12, R17
          if (xfer) begin
            // Posted word is shown one cycle after the transfer
            s_nxt.wlq   = s_r.wide ? ~pci_in.cbe_n : {LANES_OFF, ~pci_in.cbe_n[3:0]}; // see R12, R16
            s_nxt.wdata = pci_in.ad; // see R5, R8
          end
        end else begin
          // Read: fetch while room, backend avail and master ready
          // A last word with nothing queued or in flight is still fetched
          issue = backend_read_avail && !pci_in.irdy_n &&
                  (!pci_in.frame_n || (used == '0)) &&
                  (used < RQ_DEPTH4); // see R15, R16, R20
          s_nxt.fetch = issue ? (s_r.wide ? FETCH_WIDE : FETCH_NARROW) : '0;
          s_nxt.pend  = s_r.pend + {3'h0, issue} - {3'h0, cap}; // see R21, R22
          // Drain the output stage, then refill from the queue
          if (xfer) begin
            s_nxt.trdy_n = 1'b1; // see R5
          end
          if ((s_r.trdy_n || xfer) && (s_r.occ != '0)) begin
            pop          = 1'b1;
            s_nxt.ad_out = s_r.rq[0];
            s_nxt.trdy_n = 1'b0; // see R15
          end
          s_nxt.occ = s_r.occ - {3'h0, pop};
          if (pop) begin
            for (int i = 0; i < RQ_DEPTH - 1; i++) begin
              s_nxt.rq[i] = s_r.rq[i+1];
            end
          end
          if (cap) begin
            s_nxt.rq[s_nxt.occ[1:0]] = mem_rdata;
            s_nxt.occ = s_nxt.occ + 4'h1;
          end
        end
        // Master end or abandon releases the bus
        if (fin || quit) begin
          s_nxt.phase    = PH_IDLE; // see R8, R10, R25
          s_nxt.trdy_n   = 1'b1;
          s_nxt.devsel_n = 1'b1;
          s_nxt.ack64_n  = 1'b1;
          s_nxt.ad_oe    = 1'b0;
          s_nxt.fetch    = '0;
          s_nxt.occ      = '0;
          s_nxt.pend     = '0;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      s_r          <= '0;
      s_r.phase    <= PH_IDLE;
      s_r.frame_q  <= 1'b1;
      s_r.devsel_n <= 1'b1;
      s_r.ack64_n  <= 1'b1;
      s_r.trdy_n   <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from state
  assign devsel_n             = s_r.devsel_n;
  assign ack64_n              = s_r.ack64_n;
  assign trdy_n               = s_r.trdy_n;
  assign ad_out               = s_r.ad_out;
  assign ad_oe                = s_r.ad_oe;
  assign cyc                  = s_r.cyc;
  assign mem_addr             = s_r.mem_addr;
  assign mem_wdata            = s_r.wdata;
  assign write_lane_qualifier = s_r.wlq;
  assign read_fetch_strobe    = s_r.fetch;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_CLAIM: assert property (cyc.hit_strobe |=> !devsel_n ##1 !devsel_n) // see R3
    else $error("hit strobe not followed by claim");
  AST_WIDE: assert property (cyc.wide_strobe |-> cyc.hit_strobe ##1 !ack64_n) // see R4
    else $error("wide hit without claim of wide path");
  AST_DIR_WR: assert property (start && (cmd == CMD_MEM_WRITE) |=> cyc.dir_write_flag) // see R1
    else $error("memory write not flagged");
  AST_DIR_RD: assert property (start && (cmd == CMD_MEM_READ) |=> cyc.dir_read_flag) // see R2
    else $error("memory read not flagged");
  AST_STEP: assert property ((read_fetch_strobe != '0) |=> // see R6
      (mem_addr == $past(mem_addr) + ($past(s_r.wide) ? STEP_WIDE : STEP_NARROW)))
    else $error("read pointer step wrong");
  AST_WR_RDY: assert property ((s_r.phase == PH_DATA) && !s_r.is_read && // see R12
      backend_write_accept && !pci_in.frame_n |=> !trdy_n)
    else $error("write ready did not follow accept");
  AST_WR_NOTRDY: assert property ((s_r.phase == PH_DATA) && !s_r.is_read && // see R17
      !backend_write_accept |=> trdy_n)
    else $error("write ready held without accept");
  AST_WR_QUAL: assert property (xfer && !s_r.is_read && (s_r.phase == PH_DATA) |=> // see R12
      (write_lane_qualifier != '0) && (mem_wdata == $past(pci_in.ad)))
    else $error("write word not posted");
  AST_PAUSE: assert property (pci_in.irdy_n |=> (read_fetch_strobe == '0) && // see R16
      (write_lane_qualifier == '0))
    else $error("qualifier active during master wait");
  AST_AVAIL: assert property (!backend_read_avail |=> (read_fetch_strobe == '0)) // see R20
    else $error("fetch after avail dropped");
  AST_HOLD: assert property (!cyc.hit_strobe |-> // see R23
      $stable({cyc.space_select_flags, cyc.dir_read_flag, cyc.dir_write_flag}))
    else $error("cycle flags changed between hits");
  AST_END: assert property (fin && (s_r.phase == PH_DATA) |=> trdy_n && devsel_n && // see R25
      (read_fetch_strobe == '0))
    else $error("target still active after master end");
  AST_HIT_PULSE: assert property (cyc.hit_strobe |=> !cyc.hit_strobe) // see R3
    else $error("hit strobe longer than one cycle");
  AST_NARROW: assert property (cyc.hit_strobe && !cyc.wide_strobe |-> ##2 ack64_n) // see R4
    else $error("wide path claimed without wide request");
  AST_FETCH_W: assert property ((read_fetch_strobe != '0) |-> // see R24
      (read_fetch_strobe == (s_r.wide ? FETCH_WIDE : FETCH_NARROW)))
    else $error("fetch strobe width wrong");
  AST_STEP_WR: assert property ((write_lane_qualifier != '0) |=> // see R7
      (mem_addr == $past(mem_addr) + ($past(s_r.wide) ? STEP_WIDE : STEP_NARROW)))
    else $error("write pointer step wrong");
  AST_RD_FETCH: assert property ((s_r.phase == PH_DATA) && s_r.is_read && // see R15
      backend_read_avail && !pci_in.irdy_n && (used == '0) |=> (read_fetch_strobe != '0))
    else $error("no fetch with avail and empty queue");
  AST_LANES: assert property (!s_r.wide && (write_lane_qualifier != '0) |-> // see R12
      (write_lane_qualifier[7:4] == LANES_OFF))
    else $error("upper lanes active on narrow write");
  AST_RD_OE: assert property ((s_r.phase == PH_DATA) && s_r.is_read |-> ad_oe) // see R2
    else $error("read data phase without drive");
  AST_QUIT: assert property (quit && (s_r.phase == PH_DATA) |=> trdy_n && devsel_n && // see R25
      ack64_n && !ad_oe)
    else $error("target still active after abandon");

endmodule

`default_nettype wire

// >>> tb/ptbd_master_model.sv
/*
  PCI bus master model that issues memory transactions to the target.
  Assumes the bench calls xfer just after a clock edge, one at a time.
*/
`timescale 1ns/100ps
`default_nettype none

module ptbd_master_model
  import ptbd_pkg::*;
(
  // Clock and target answers
  input  wire logic                   clk,
  input  wire logic                   devsel_n,
  input  wire logic                   trdy_n,
  // Bus drive
  output var  ptbd_pkg::ptbd_pci_in_t pci
);
  // ==========================================================
  // Idle bus after time zero
  initial begin
    pci = '{frame_n: 1'b1, irdy_n: 1'b1, req64_n: 1'b1, cbe_n: 8'hFF, ad: '0};
  end

  // Word pattern stored at a dword pointer
  function automatic logic [63:0] wv(input logic [29:0] a);
    return {~a, 4'h5, a};
  endfunction

  // ==========================================================
  // Address phase, then data phases until done or no claim
  task automatic xfer(input logic [3:0] c, input logic [31:0] a, input int n,
                      input logic w, input logic pz, input logic [7:0] be);
    logic [29:0] p;
    int          k;
    int          g;
    logic        ok;
    p           = a[31:2];
    pci.frame_n = 1'b0;
    pci.req64_n = ~w;
    pci.cbe_n   = {4'hF, c};
    pci.ad      = {32'h0000_0000, a};
    @(posedge clk);
    #1;
    pci.cbe_n = be;
    for (k = 0; k < n; k++) begin
      pci.ad = wv(p);
      // Optional wait state before asserting ready
      if (pz && $urandom_range(2) == 0) begin
        pci.irdy_n = 1'b1;
        @(posedge clk);
        #1;
      end
      pci.irdy_n  = 1'b0;
      pci.frame_n = (k == n - 1);
      g           = 0;
      do begin
        @(posedge clk);
        ok = ~trdy_n;
        g++;
      end while (!ok && g < 60 && !(devsel_n && g > 5));
      #1;
      if (!ok) break;
      p = p + (w ? 30'h0000_0002 : 30'h0000_0001);
    end
    // Release: address lines show a changed pattern
    pci = '{frame_n: 1'b1, irdy_n: 1'b1, req64_n: 1'b1, cbe_n: 8'hFF, ad: ~pci.ad};
    @(posedge clk);
    #1;
  endtask

endmodule

`default_nettype wire

// >>> tb/ptbd_top_tb.sv
/*
  Self-checking bench for the PCI target data path: corner and random
  memory bursts through a master model, with a behavioural backend.
  Assumes the package and the master model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none

module ptbd_top_tb;
  import ptbd_pkg::*;
  // ==========================================================
  // Signals
  logic         clk = 1'b0;
  logic         reset = 1'b1;
  ptbd_pci_in_t pci;
  ptbd_cyc_t    cyc;
  logic         devsel_n, ack64_n, trdy_n, ad_oe, acc, avl, pace, eh, ew;
  logic         fp = 1'b1;
  logic [63:0]  ad_out, mem_wdata, mem_rdata, msk;
  logic [31:0]  bar0, bar1;
  logic [29:0]  mem_addr, ea, st, fa;
  logic [29:0]  ah [8];
  logic [7:0]   wlq, be, el;
  logic [3:0]   ef;
  logic [3:0]   hf = 4'h0;
  logic [2:0]   lag;
  logic [1:0]   rfs;
  int           errors, checks, nw, cy;
  int           t0 = -10;

  // Word pattern the backend holds at a dword pointer
  function automatic logic [63:0] wv(input logic [29:0] a);
    return {~a, 4'h5, a};
  endfunction

  always #5 clk = ~clk;

  ptbd_top u_dut (.clk(clk), .reset(reset), .pci_in(pci), .devsel_n(devsel_n),
    .ack64_n(ack64_n), .trdy_n(trdy_n), .ad_out(ad_out), .ad_oe(ad_oe),
    .bar0_base(bar0), .bar1_base(bar1), .addr_data_lag_sel(lag),
    .backend_write_accept(acc), .backend_read_avail(avl), .mem_rdata(mem_rdata),
    .cyc(cyc), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .write_lane_qualifier(wlq), .read_fetch_strobe(rfs));
  ptbd_master_model u_mst (.clk(clk), .devsel_n(devsel_n), .trdy_n(trdy_n), .pci(pci));

  // ==========================================================
  // Backend: data N cycles after its address, random pacing
  assign mem_rdata = (lag == 3'h0) ? wv(mem_addr) : wv(ah[lag - 3'h1]);
  always @(posedge clk) begin
    for (int i = 7; i > 0; i--) ah[i] <= ah[i - 1];
    ah[0] <= mem_addr;
    #1;
    acc <= ~pace | ($urandom_range(3) != 0);
    avl <= ~pace | ($urandom_range(3) != 0);
  end

  // Compare tasks
  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ==========================================================
  // Monitor: claim timing, backend words and read data
  always @(posedge clk) begin
    cy++;
    if (!pci.frame_n && fp) t0 = cy;
    fp = pci.frame_n;
    if (cy == t0 + 1) begin
      chk_bit(cyc.hit_strobe, eh);
      chk_bit(cyc.wide_strobe, eh & ew);
      if (eh) chk_word(64'({cyc.space_select_flags, cyc.dir_read_flag, cyc.dir_write_flag,
                            mem_addr}), 64'({ef, ea}));
    end
    if (cy == t0 + 2) begin
      chk_bit(devsel_n, ~eh);
      chk_bit(ack64_n, ~(eh & ew));
    end
    if (|wlq) begin
      chk_word(mem_wdata & msk, wv(ea) & msk);
      chk_word(64'({wlq, mem_addr}), 64'({el, ea}));
      ea += st;
      nw++;
    end
    if (!trdy_n && !pci.irdy_n && ad_oe) begin
      chk_word(ad_out & msk, wv(ea) & msk);
      ea += st;
      nw++;
    end
    if (|rfs) begin
      chk_bit(rfs[1], ew);
      chk_word(64'(mem_addr), 64'(fa));
      fa += st;
    end
    if (cy > 20000) begin
      errors++;
      finish_test;
    end
  end

  // One transaction with its expectations
  task automatic run(input logic [3:0] c, input int s, input int n, input logic w,
                     input logic pz, input logic pc, input logic [2:0] lg);
    logic [31:0] a;
    a    = ((s == 1) ? bar1 : (s == 0) ? bar0 : ~bar0) & 32'hFFFF_F000;
    a    = a | {22'h00_0000, 8'($urandom), 2'h0};
    eh   = (s < 2) && (c == CMD_MEM_READ || c == CMD_MEM_WRITE);
    ew   = w;
    ea   = a[31:2];
    fa   = a[31:2];
    st   = w ? 30'h0000_0002 : 30'h0000_0001;
    nw   = 0;
    pace = pc;
    lag  = lg;
    be   = 8'($urandom) & 8'hFE;
    el   = w ? ~be : {4'h0, ~be[3:0]};
    msk  = w ? '1 : 64'h0000_0000_FFFF_FFFF;
    ef   = {s == 1, s == 0, c == CMD_MEM_READ, c == CMD_MEM_WRITE};
    if (eh) hf = ef;
    @(posedge clk);
    #1;
    u_mst.xfer(c, a, n, w, pz, be);
    repeat (3) @(posedge clk);
    #1;
    chk_word(64'(nw), eh ? 64'(n) : 64'h0000_0000_0000_0000);
    chk_bit(trdy_n & devsel_n & ~ad_oe & ~|wlq & ~|rfs, 1'b1);
    chk_word(64'({cyc.space_select_flags, cyc.dir_read_flag, cyc.dir_write_flag}),
             64'(hf));
    $display("test done: cmd %h words %0d", c, nw);
  endtask

  // Closing report
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence: corner cases, then random bursts
  initial begin
    void'($urandom(32'h17b8c8ad));
    acc  = 1'b1;
    avl  = 1'b1;
    pace = 1'b0;
    lag  = 3'h0;
    bar0 = $urandom() & 32'hFFF0_0000;
    bar1 = bar0 ^ 32'h0010_0000;
    repeat (3) @(posedge clk);
    #1;
    reset = 1'b0;
    run(CMD_MEM_WRITE, 0, 4, 1'b0, 1'b0, 1'b0, 3'h0);
    run(CMD_MEM_WRITE, 1, 4, 1'b1, 1'b0, 1'b0, 3'h0);
    run(CMD_MEM_READ, 0, 5, 1'b0, 1'b0, 1'b0, 3'h0);
    run(CMD_MEM_READ, 1, 4, 1'b1, 1'b0, 1'b0, 3'h0);
    run(CMD_MEM_WRITE, 2, 1, 1'b0, 1'b0, 1'b0, 3'h0);
    run(4'h2, 0, 1, 1'b0, 1'b0, 1'b0, 3'h0);
    run(CMD_MEM_READ, 0, 6, 1'b0, 1'b1, 1'b1, 3'h3);
    for (int i = 0; i < 16; i++) begin
      run($urandom_range(1) ? CMD_MEM_READ : CMD_MEM_WRITE, $urandom_range(1),
          $urandom_range(8, 1), 1'($urandom), 1'($urandom), 1'($urandom),
          3'($urandom));
    end
    finish_test;
  end

endmodule

`default_nettype wire
